/* inc/pm_setpoint_pkg.sv */
// Constants for the profile motion setpoint unit: object indices,
// control/status bit positions, reset values and timing.
// Assumes a single 100 MHz clock domain.
package pm_setpoint_pkg;
  // ----------------------------------------------------------------
  // Object indices
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_FAULT_CODE = 16'h603F;
  localparam logic [15:0] IDX_CONTROL = 16'h6040;
  localparam logic [15:0] IDX_STATUS = 16'h6041;
  localparam logic [15:0] IDX_HALT_OPTION = 16'h605D;
  localparam logic [15:0] IDX_MODE_SELECT = 16'h6060;
  localparam logic [15:0] IDX_MODE_SHOWN = 16'h6061;
  localparam logic [15:0] IDX_POS_ENCODER = 16'h6063;
  localparam logic [15:0] IDX_POS_COMMAND = 16'h6064;
  localparam logic [15:0] IDX_FOLLOW_LIMIT = 16'h6065;
  localparam logic [15:0] IDX_REACH_THRESH = 16'h6067;
  localparam logic [15:0] IDX_REACH_WINDOW = 16'h6068;
  localparam logic [15:0] IDX_SPEED_ACTUAL = 16'h606C;
  localparam logic [15:0] IDX_SPEED_THRESH = 16'h606D;
  localparam logic [15:0] IDX_SPEED_WINDOW = 16'h606E;
  localparam logic [15:0] IDX_TORQUE_ACTUAL = 16'h6077;
  localparam logic [15:0] IDX_TARGET_POS = 16'h607A;
  localparam logic [15:0] IDX_SPEED_CEIL = 16'h607F;
  localparam logic [15:0] IDX_PROFILE_VEL = 16'h6081;
  localparam logic [15:0] IDX_ACCEL = 16'h6083;
  localparam logic [15:0] IDX_DECEL = 16'h6084;
  localparam logic [15:0] IDX_TORQUE_POS = 16'h60E0;
  localparam logic [15:0] IDX_TORQUE_NEG = 16'h60E1;
  localparam logic [15:0] IDX_SPEED_TARGET = 16'h60FF;
  // ----------------------------------------------------------------
  // Control and status word bits
  // ----------------------------------------------------------------
  localparam int CW_NEW_SETPOINT = 4;
  localparam int CW_IMMEDIATE = 5;
  localparam int CW_RELATIVE = 6;
  localparam int CW_FAULT_RESET = 7;
  localparam int CW_HALT = 8;
  localparam int CW_BLEND = 9;
  localparam logic [3:0] CW_RUN_MASK = 4'hF;
  localparam int SW_TARGET_REACHED = 10;
  localparam int SW_INTERNAL_LIMIT = 11;
  localparam int SW_SETPOINT_ACK = 12;
  localparam int SW_FOLLOW_ERROR = 13;
  localparam int SW_HOME_FOUND = 15;
  // ----------------------------------------------------------------
  // Reset values and special codes
  // ----------------------------------------------------------------
  localparam logic [31:0] FOLLOW_DISABLE = 32'h0FFFFFFF;
  localparam logic [31:0] RST_FOLLOW_LIMIT = 32'h00100000;
  localparam logic [31:0] RST_REACH_THRESH = 32'h000002DE;
  localparam logic [15:0] RST_REACH_WINDOW = 16'h000A;
  localparam logic [31:0] RST_SPEED_CEIL = 32'h000000E6;
  localparam logic [15:0] RST_TORQUE_LIMIT = 16'h1388;
  localparam logic [31:0] RST_ACCEL = 32'h00000064;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    PLAN_IDLE = 2'b00,
    PLAN_MOVING = 2'b01,
    PLAN_QUEUED = 2'b11
  } plan_state_t;
endpackage

/* verilog/profile_motion_setpoint_unit.sv */
// Setpoint handshake, planner hand-off and status word logic of a
// servo drive in profile position and profile velocity modes.
// Assumes the servo loops supply deviation, speed and limit inputs
// synchronous to sys_clk, and odSync marks each process-data cycle.
`timescale 1ns/1ps
// Behaviour
// (R01) In-band deviation for window time sets reached
// (R02) Either condition failing clears reached
// (R03) Deviation over limit raises following error
// (R04) All-ones limit disables following error check; the code disables it at FOLLOW_DISABLE (0FFFFFFF) instead
// (R05) Control bit 5 selects single or multi-point
// (R06) Bit 4 rising edge loads new target
// (R07) Take sets ack; next only when ack clear
// (R08) Single-point edge replans at once
// (R09) Bit 9 clear: queued point follows completion
// (R10) Bit 9 set: trigger speed starts next move
// (R11) Controller maps required process data objects
// (R12) Velocity mode: controller gives speed and ramps
// (R13) Run only when control bits 0-3 set
// (R14) Bit 8 pauses motion per halt option
// (R15) Status bit 10 shows target reached
// (R16) Status bit 11 follows internal limit
// (R17) Status bit 15 set once homing done
// (R18) Velocity mode speed reached after window
// (R19) One acceptance per sampled bit 4 edge
module profile_motion_setpoint_unit #(
  parameter logic [7:0] MODE_PROFILE_POSITION = 8'h01,
  parameter logic [7:0] MODE_PROFILE_VELOCITY = 8'h03,
  parameter logic [15:0] FAULT_FOLLOWING = 16'h0001, // Arbitrary value
  parameter int MS_CYCLES_P = pm_setpoint_pkg::MS_CYCLES
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic odWrEn, // Object write strobe
  input wire logic odRdEn, // Object read strobe
  input wire logic [15:0] odIndex, // Object index
  input wire logic [31:0] odWrData, // Write data
  output logic [31:0] odRdData, // Read data, registered
  output logic odRdValid, // Read data valid pulse
  output logic odAccessErr, // Unknown index or RO write
  input wire logic odSync, // Process-data cycle boundary
  input wire logic signed [31:0] posDeviation, // Following deviation
  input wire logic signed [31:0] speedActualIn, // Measured speed
  input wire logic [15:0] torqueActualIn, // Measured torque
  input wire logic [31:0] posEncoderIn, // Feedback, encoder units
  input wire logic [31:0] posCommandIn, // Feedback, command units
  input wire logic cmdOverLimit, // Position command over limit
  input wire logic fbOverLimit, // Position feedback over limit
  input wire logic homeDone, // Homing sequence finished
  input wire logic planDone, // Planner finished current point
  output logic driveRun, // Operation enabled
  output logic haltActive, // Pause per halt option
  output logic [15:0] haltOption, // Halt option code
  output logic setpointLoad, // Hand new point to planner
  output logic setpointReplan, // Abort current plan, replan
  output logic setpointRelative, // Target is relative
  output logic [31:0] setpointTarget, // Target position
  output logic [31:0] setpointVelocity, // Profile velocity
  output logic [31:0] setpointAccel, // Acceleration
  output logic [31:0] setpointDecel, // Deceleration
  output logic blendEnable, // Start next move at blendSpeed
  output logic [31:0] blendSpeed, // Speed at trigger edge
  output logic positioningDone, // Positioning complete output
  output logic speedReachedOut, // Speed reached output
  output logic followAlarm // Panel alarm, following error
);
  import pm_setpoint_pkg::*;

  initial begin
    if (MS_CYCLES_P < 1) begin
      $error("MS_CYCLES_P must be at least one");
    end
  end

  // ----------------------------------------------------------------
  // Object store
  // ----------------------------------------------------------------
  logic [15:0] controlReg, faultCodeReg, statusReg, haltOptReg;
  logic [7:0] modeSelReg, modeShownReg;
  logic [31:0] followLimReg, reachThrReg, speedThrReg, speedCeilReg;
  logic [15:0] reachWinReg, speedWinReg, torqPosReg, torqNegReg;
  logic [31:0] targetPosReg, profVelReg, accelReg, decelReg;
  logic [31:0] speedTgtReg;
  logic wrOk;

  always_comb begin
    case (odIndex)
      IDX_CONTROL, IDX_HALT_OPTION, IDX_MODE_SELECT, IDX_FOLLOW_LIMIT,
      IDX_REACH_THRESH, IDX_REACH_WINDOW, IDX_SPEED_THRESH,
      IDX_SPEED_WINDOW, IDX_TARGET_POS, IDX_SPEED_CEIL,
      IDX_PROFILE_VEL, IDX_ACCEL, IDX_DECEL, IDX_TORQUE_POS,
      IDX_TORQUE_NEG, IDX_SPEED_TARGET: wrOk = 1'b1;
      default: wrOk = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      controlReg <= '0;
      haltOptReg <= '0;
      modeSelReg <= '0;
      followLimReg <= RST_FOLLOW_LIMIT;
      reachThrReg <= RST_REACH_THRESH;
      reachWinReg <= RST_REACH_WINDOW;
      speedThrReg <= '0;
      speedWinReg <= '0;
      targetPosReg <= '0;
      speedCeilReg <= RST_SPEED_CEIL;
      profVelReg <= '0;
      accelReg <= RST_ACCEL;
      decelReg <= RST_ACCEL;
      torqPosReg <= RST_TORQUE_LIMIT;
      torqNegReg <= RST_TORQUE_LIMIT;
      speedTgtReg <= '0;
    end else if (odWrEn && wrOk) begin
      case (odIndex)
        IDX_CONTROL: controlReg <= odWrData[15:0];
        IDX_HALT_OPTION: haltOptReg <= odWrData[15:0];
        IDX_MODE_SELECT: modeSelReg <= odWrData[7:0];
        IDX_FOLLOW_LIMIT: followLimReg <= odWrData;
        IDX_REACH_THRESH: reachThrReg <= odWrData;
        IDX_REACH_WINDOW: reachWinReg <= odWrData[15:0];
        IDX_SPEED_THRESH: speedThrReg <= odWrData;
        IDX_SPEED_WINDOW: speedWinReg <= odWrData[15:0];
        IDX_TARGET_POS: targetPosReg <= odWrData;
        IDX_SPEED_CEIL: speedCeilReg <= odWrData;
        IDX_PROFILE_VEL: profVelReg <= odWrData;
        IDX_ACCEL: accelReg <= odWrData;
        IDX_DECEL: decelReg <= odWrData;
        IDX_TORQUE_POS: torqPosReg <= odWrData[15:0];
        IDX_TORQUE_NEG: torqNegReg <= odWrData[15:0];
        default: speedTgtReg <= odWrData; // [R12]
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      odRdData <= '0;
      odRdValid <= 1'b0;
      odAccessErr <= 1'b0;
    end else begin
      odRdValid <= odRdEn;
      odAccessErr <= odWrEn && !wrOk;
      if (odRdEn) begin
        case (odIndex)
          IDX_FAULT_CODE: odRdData <= {16'h0000, faultCodeReg};
          IDX_CONTROL: odRdData <= {16'h0000, controlReg};
          IDX_STATUS: odRdData <= {16'h0000, statusReg};
          IDX_HALT_OPTION: odRdData <= {16'h0000, haltOptReg};
          IDX_MODE_SELECT: odRdData <= {24'h000000, modeSelReg};
          IDX_MODE_SHOWN: odRdData <= {24'h000000, modeShownReg};
          IDX_POS_ENCODER: odRdData <= posEncoderIn;
          IDX_POS_COMMAND: odRdData <= posCommandIn;
          IDX_FOLLOW_LIMIT: odRdData <= followLimReg;
          IDX_REACH_THRESH: odRdData <= reachThrReg;
          IDX_REACH_WINDOW: odRdData <= {16'h0000, reachWinReg};
          IDX_SPEED_ACTUAL: odRdData <= speedActualIn;
          IDX_SPEED_THRESH: odRdData <= speedThrReg;
          IDX_SPEED_WINDOW: odRdData <= {16'h0000, speedWinReg};
          IDX_TORQUE_ACTUAL: odRdData <= {16'h0000, torqueActualIn};
          IDX_TARGET_POS: odRdData <= targetPosReg;
          IDX_SPEED_CEIL: odRdData <= speedCeilReg;
          IDX_PROFILE_VEL: odRdData <= profVelReg;
          IDX_ACCEL: odRdData <= accelReg;
          IDX_DECEL: odRdData <= decelReg;
          IDX_TORQUE_POS: odRdData <= {16'h0000, torqPosReg};
          IDX_TORQUE_NEG: odRdData <= {16'h0000, torqNegReg};
          IDX_SPEED_TARGET: odRdData <= speedTgtReg;
          default: odRdData <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Operating state and setpoint edge
  // ----------------------------------------------------------------
  logic ppMode, pvMode, cwBit4Prev, cwBit7Prev, newEdge, takeReg;
  assign ppMode = (modeShownReg == MODE_PROFILE_POSITION);
  assign pvMode = (modeShownReg == MODE_PROFILE_VELOCITY);
  assign driveRun = (controlReg[3:0] == CW_RUN_MASK); // [R13]
  assign haltActive = driveRun && controlReg[CW_HALT]; // [R14]
  assign haltOption = haltOptReg; // [R14]
  // Edge taken between successive process-data samples only
  assign newEdge = odSync && controlReg[CW_NEW_SETPOINT] &&
                   !cwBit4Prev; // [R19]

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cwBit4Prev <= 1'b0;
      cwBit7Prev <= 1'b0;
      modeShownReg <= '0;
    end else begin
      modeShownReg <= modeSelReg;
      if (odSync) begin
        cwBit4Prev <= controlReg[CW_NEW_SETPOINT]; // [R19]
        cwBit7Prev <= controlReg[CW_FAULT_RESET];
      end
    end
  end

  // ----------------------------------------------------------------
  // Planner hand-off
  // ----------------------------------------------------------------
  plan_state_t planReg, planNext;
  logic ackReg, canTake, single;
  logic [31:0] pendTarget, pendVel;
  logic pendRel;
  assign single = controlReg[CW_IMMEDIATE]; // [R05]
  // Multi-point holds one queued point; further edges wait for ack
  assign canTake = newEdge && driveRun && ppMode && !ackReg &&
                   (single || planReg != PLAN_QUEUED); // [R07]

  always_comb begin
    planNext = planReg;
    case (planReg)
      PLAN_IDLE: if (canTake) planNext = PLAN_MOVING; // [R06]
      PLAN_MOVING: begin
        if (canTake && !single) begin
          planNext = PLAN_QUEUED; // [R09]
        end else if (planDone && !canTake) begin
          planNext = PLAN_IDLE;
        end
      end
      PLAN_QUEUED: if (planDone) planNext = PLAN_MOVING; // [R09]
      default: planNext = PLAN_IDLE;
    endcase
    if (!ppMode) begin
      planNext = PLAN_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      planReg <= PLAN_IDLE;
      takeReg <= 1'b0;
      setpointLoad <= 1'b0;
      setpointReplan <= 1'b0;
      setpointRelative <= 1'b0;
      setpointTarget <= '0;
      setpointVelocity <= '0;
      setpointAccel <= '0;
      setpointDecel <= '0;
      pendTarget <= '0;
      pendVel <= '0;
      pendRel <= 1'b0;
      blendEnable <= 1'b0;
      blendSpeed <= '0;
    end else begin
      planReg <= planNext;
      takeReg <= canTake;
      setpointLoad <= 1'b0;
      setpointReplan <= 1'b0;
      if (canTake && (single || planReg == PLAN_IDLE)) begin
        setpointLoad <= 1'b1; // [R06]
        setpointReplan <= single && planReg != PLAN_IDLE; // [R08]
        setpointTarget <= targetPosReg;
        setpointVelocity <= profVelReg;
        setpointRelative <= controlReg[CW_RELATIVE];
        setpointAccel <= accelReg;
        setpointDecel <= decelReg;
        blendEnable <= 1'b0;
      end else if (canTake) begin
        pendTarget <= targetPosReg; // [R09]
        pendVel <= profVelReg;
        pendRel <= controlReg[CW_RELATIVE];
        // Speed at the trigger edge seeds the next move
        blendEnable <= controlReg[CW_BLEND]; // [R10]
        blendSpeed <= speedActualIn; // [R10]
      end else if (planReg == PLAN_QUEUED && planDone) begin
        setpointLoad <= 1'b1; // [R09]
        setpointTarget <= pendTarget;
        setpointVelocity <= pendVel;
        setpointRelative <= pendRel;
        setpointAccel <= accelReg;
        setpointDecel <= decelReg;
      end
    end
  end

  // Ack stays set while a point waits, so the master cannot overrun
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ackReg <= 1'b0;
    end else if (canTake) begin
      ackReg <= 1'b1; // [R07]
    end else if (odSync && !controlReg[CW_NEW_SETPOINT] &&
                 planReg != PLAN_QUEUED) begin
      ackReg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick and arrival windows
  // ----------------------------------------------------------------
  logic [31:0] msPresc;
  logic msTick, posInBand, spdInBand, posReached, spdReached;
  logic [15:0] posMs, spdMs;
  logic [32:0] devAbs, spdDiffAbs, spdDiff;
  assign msTick = (msPresc == 32'(MS_CYCLES_P - 1));
  assign devAbs = posDeviation[31] ? 33'(-{posDeviation[31], posDeviation})
                                   : {1'b0, posDeviation};
  assign spdDiff = {speedTgtReg[31], speedTgtReg} -
                   {speedActualIn[31], speedActualIn};
  assign spdDiffAbs = spdDiff[32] ? 33'(-spdDiff) : spdDiff;
  assign posInBand = devAbs <= {1'b0, reachThrReg}; // [R01]
  assign spdInBand = spdDiffAbs <= {1'b0, speedThrReg}; // [R18]

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      msPresc <= '0;
    end else begin
      msPresc <= msTick ? '0 : msPresc + 32'h00000001;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      posMs <= '0;
    end else if (!posInBand) begin
      posMs <= '0; // [R02]
    end else if (msTick && posMs != 16'hFFFF) begin
      posMs <= posMs + 16'h0001; // [R01]
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      spdMs <= '0;
    end else if (!spdInBand || !driveRun) begin
      spdMs <= '0;
    end else if (msTick && spdMs != 16'hFFFF) begin
      spdMs <= spdMs + 16'h0001; // [R18]
    end
  end

  // Reached only while both in band and window elapsed
  assign posReached = posInBand && (posMs >= reachWinReg); // [R01] [R02]
  assign spdReached = driveRun && pvMode && spdInBand &&
                      (spdMs >= speedWinReg); // [R18]

  // ----------------------------------------------------------------
  // Following error and status word
  // ----------------------------------------------------------------
  logic followErr, followHit, homeFound;
  assign followHit = (followLimReg != FOLLOW_DISABLE) &&
                     (devAbs > {1'b0, followLimReg}); // [R03] [R04]
  assign followAlarm = followErr; // [R03]

  // A fresh violation beats a fault reset in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      followErr <= 1'b0;
      faultCodeReg <= '0;
    end else if (followHit) begin
      followErr <= 1'b1; // [R03]
      faultCodeReg <= FAULT_FOLLOWING;
    end else if (odSync && controlReg[CW_FAULT_RESET] && !cwBit7Prev) begin
      followErr <= 1'b0;
      faultCodeReg <= '0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      homeFound <= 1'b0;
      positioningDone <= 1'b0;
      speedReachedOut <= 1'b0;
      statusReg <= '0;
    end else begin
      if (homeDone) begin
        homeFound <= 1'b1; // [R17]
      end
      positioningDone <= ppMode && posReached; // [R01]
      speedReachedOut <= spdReached; // [R18]
      statusReg <= '0;
      statusReg[3:0] <= controlReg[3:0];
      statusReg[SW_TARGET_REACHED] <= (ppMode && posReached) ||
                                      spdReached; // [R15]
      statusReg[SW_INTERNAL_LIMIT] <= cmdOverLimit || fbOverLimit; // [R16]
      statusReg[SW_SETPOINT_ACK] <= ackReg; // [R07]
      statusReg[SW_FOLLOW_ERROR] <= followErr; // [R03]
      statusReg[SW_HOME_FOUND] <= homeFound || homeDone; // [R17]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence takeSeq;
    canTake && (planReg == PLAN_IDLE || single);
  endsequence
  sequence loadSeq;
    setpointLoad && !$past(setpointLoad);
  endsequence

  AST_LOAD_AFTER_TAKE: assert property (@(posedge sys_clk) // [R06]
    disable iff (!resetn) takeSeq |=> loadSeq)
    else $error("setpoint not loaded after take");
  AST_ACK_AFTER_TAKE: assert property (@(posedge sys_clk) // [R07]
    disable iff (!resetn) canTake |=> ##1 statusReg[SW_SETPOINT_ACK])
    else $error("ack not shown after take");
  AST_ONE_TAKE_PER_EDGE: assert property (@(posedge sys_clk) // [R19]
    disable iff (!resetn) canTake |=> !canTake)
    else $error("two acceptances for one edge");
  AST_REPLAN_SINGLE: assert property (@(posedge sys_clk) // [R08]
    disable iff (!resetn)
    canTake && single && planReg == PLAN_MOVING |=> setpointReplan)
    else $error("single-point edge did not replan");
  AST_QUEUE_ON_DONE: assert property (@(posedge sys_clk) // [R09]
    disable iff (!resetn)
    planReg == PLAN_QUEUED && planDone |=> setpointLoad)
    else $error("queued point not started");
  AST_REACH_DROPS: assert property (@(posedge sys_clk) // [R02]
    disable iff (!resetn) ppMode && !posInBand |=> !positioningDone)
    else $error("reached held outside band");
  AST_REACH_NEEDS_WINDOW: assert property (@(posedge sys_clk) // [R01]
    disable iff (!resetn)
    $rose(positioningDone) |-> $past(posMs) >= reachWinReg)
    else $error("reached before window elapsed");
  AST_FOLLOW_SETS: assert property (@(posedge sys_clk) // [R03]
    disable iff (!resetn) followHit |=> ##1 statusReg[SW_FOLLOW_ERROR])
    else $error("following error not reported");
  AST_FOLLOW_OFF: assert property (@(posedge sys_clk) // [R04]
    disable iff (!resetn)
    followLimReg == FOLLOW_DISABLE && !followErr |=> !followErr)
    else $error("detection ran while disabled");
  AST_LIMIT_BIT: assert property (@(posedge sys_clk) // [R16]
    disable iff (!resetn)
    (cmdOverLimit || fbOverLimit) |=> statusReg[SW_INTERNAL_LIMIT])
    else $error("internal limit bit missing");
  AST_HOME_STICKY: assert property (@(posedge sys_clk) // [R17]
    disable iff (!resetn)
    statusReg[SW_HOME_FOUND] |=> statusReg[SW_HOME_FOUND])
    else $error("home found bit dropped");
  AST_RUN_ONLY_ALL: assert property (@(posedge sys_clk) // [R13]
    disable iff (!resetn) canTake |-> controlReg[3:0] == CW_RUN_MASK)
    else $error("took setpoint without run");
endmodule // profile_motion_setpoint_unit

/* test/motion_master_model.sv */
// Upper controller model: paces process-data cycles and finishes
// planned points some cycles after each load. One 100 MHz clock.
`timescale 1ns/1ps
module motion_master_model #(
  parameter int SYNC_DIV = 8,
  parameter int PLAN_LEN = 300
) (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic setpointLoad, // Point handed to planner
  output logic odSync, // Process-data cycle pulse
  output logic planDone // Planner finished pulse
);
  // ----------------------------------------------------------------
  // Cycle pacing and planner completion
  // ----------------------------------------------------------------
  int syncCnt;
  int planCnt;
  // Control bits 4 and 7 are only sampled at these pulses
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      syncCnt <= 0;
      odSync <= 1'b0;
    end else begin
      syncCnt <= (syncCnt == SYNC_DIV - 1) ? 0 : syncCnt + 1;
      odSync <= (syncCnt == SYNC_DIV - 1);
    end
  end
  // Long plan keeps the move running so a new edge replans
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      planCnt <= 0;
      planDone <= 1'b0;
    end else begin
      planCnt <= setpointLoad ? PLAN_LEN : (planCnt > 0 ? planCnt - 1 : 0);
      planDone <= (planCnt == 1);
    end
  end
endmodule // motion_master_model

/* test/test_profile_motion_setpoint_unit.sv */
// Testbench for the profile motion setpoint unit.
// Assumes the controller model paces process-data cycles.
`timescale 1ns/1ps
module test_profile_motion_setpoint_unit;
  import pm_setpoint_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  logic sys_clk, resetn, odWrEn, odRdEn, odRdValid, odAccessErr, odSync;
  logic overLimit, homeDone, planDone, setpointLoad, setpointReplan;
  logic haltActive, positioningDone, followAlarm, blendEnable, speedReached;
  logic [15:0] odIndex;
  logic [31:0] odWrData, odRdData, setpointTarget, v, blendSpeed;
  logic signed [31:0] posDeviation, speedIn;
  int miscompares, checks_done;
  profile_motion_setpoint_unit #(.MS_CYCLES_P(4)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .odWrEn(odWrEn), .odRdEn(odRdEn),
    .odIndex(odIndex), .odWrData(odWrData), .odRdData(odRdData),
    .odRdValid(odRdValid), .odAccessErr(odAccessErr), .odSync(odSync),
    .posDeviation(posDeviation), .speedActualIn(speedIn),
    .torqueActualIn(16'h0), .posEncoderIn(32'h0), .posCommandIn(32'h0),
    .cmdOverLimit(overLimit), .fbOverLimit(overLimit), .homeDone(homeDone),
    .planDone(planDone), .driveRun(), .haltActive(haltActive),
    .haltOption(), .setpointLoad(setpointLoad),
    .setpointReplan(setpointReplan), .setpointRelative(),
    .setpointTarget(setpointTarget), .setpointVelocity(),
    .setpointAccel(), .setpointDecel(), .blendEnable(blendEnable),
    .blendSpeed(blendSpeed),
    .positioningDone(positioningDone), .speedReachedOut(speedReached),
    .followAlarm(followAlarm));
  motion_master_model master_u (.sys_clk(sys_clk), .resetn(resetn),
    .setpointLoad(setpointLoad), .odSync(odSync), .planDone(planDone));
  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    odIndex = i;
    odWrData = d;
    odWrEn = 1'b1;
    step();
    odWrEn = 1'b0;
    chk("odAccessErr", {31'h0, i == IDX_STATUS}, odAccessErr);
    step();
  endtask
  task automatic rd(input logic [15:0] i);
    odIndex = i;
    odRdEn = 1'b1;
    step();
    odRdEn = 1'b0;
    chk("odRdValid", 32'h1, odRdValid);
    v = odRdData;
    step();
  endtask
  task automatic wait_load(input int lim = 40);
    int k;
    for (k = 0; k < lim && setpointLoad !== 1'b1; k++) step();
    if (k == lim) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic regs_scn();
    rd(IDX_FOLLOW_LIMIT);
    chk("followLimit", RST_FOLLOW_LIMIT, v); // [REG]
    rd(IDX_REACH_THRESH);
    chk("reachThresh", RST_REACH_THRESH, v); // [REG]
    rd(IDX_STATUS);
    chk("status", 32'h0, v);
    wr(IDX_STATUS, 32'hFFFF); // [REG]
  endtask
  task automatic handshake_scn();
    wr(IDX_MODE_SELECT, 32'h1);
    wr(IDX_TARGET_POS, 32'h1234);
    wr(IDX_CONTROL, 32'h3F);
    wait_load();
    chk("target", 32'h1234, setpointTarget);
    step(2);
    rd(IDX_STATUS);
    chk("ackSet", 32'h1, v[SW_SETPOINT_ACK]);
    wr(IDX_TARGET_POS, 32'h5678);
    wr(IDX_CONTROL, 32'h2F);
    step(12);
    rd(IDX_STATUS);
    chk("ackClear", 32'h0, v[SW_SETPOINT_ACK]);
    wr(IDX_CONTROL, 32'h3F);
    wait_load();
    chk("replan", 32'h1, setpointReplan);
    chk("target2", 32'h5678, setpointTarget);
    wr(IDX_CONTROL, 32'h12F);
    chk("halt", 32'h1, haltActive);
    // Bit 4 must be seen low at a sync before the multi-point edge
    wr(IDX_TARGET_POS, 32'h9ABC);
    speedIn = 32'sh55;
    step(8);
    wr(IDX_CONTROL, 32'h21F);
    step(12);
    chk("blend", 32'h1, blendEnable);
    chk("blendSpeed", 32'h55, blendSpeed);
    wait_load(400);
    chk("target3", 32'h9ABC, setpointTarget);
  endtask
  task automatic status_scn();
    wr(IDX_REACH_WINDOW, 32'h2);
    step(16);
    chk("posDone", 32'h1, positioningDone);
    rd(IDX_STATUS);
    chk("reached", 32'h1, v[SW_TARGET_REACHED]);
    posDeviation = 32'sd800;
    step(3);
    chk("posDoneLost", 32'h0, positioningDone);
    posDeviation = 32'sd0;
    step(2);
    chk("posDoneEarly", 32'h0, positioningDone);
    step(8);
    chk("posDoneWin", 32'h1, positioningDone);
    overLimit = 1'b1;
    homeDone = 1'b1;
    step();
    homeDone = 1'b0;
    step(2);
    rd(IDX_STATUS);
    chk("limit", 32'h1, v[SW_INTERNAL_LIMIT]);
    chk("home", 32'h1, v[SW_HOME_FOUND]);
    overLimit = 1'b0;
    step(2);
    rd(IDX_STATUS);
    chk("limitOff", 32'h0, v[SW_INTERNAL_LIMIT]);
  endtask
  task automatic follow_scn();
    wr(IDX_FOLLOW_LIMIT, FOLLOW_DISABLE);
    posDeviation = 32'sh7000_0000;
    step(4);
    chk("followOff", 32'h0, followAlarm);
    wr(IDX_FOLLOW_LIMIT, 32'h100);
    step(3);
    chk("follow", 32'h1, followAlarm);
    rd(IDX_STATUS);
    chk("followBit", 32'h1, v[SW_FOLLOW_ERROR]);
    wr(IDX_MODE_SELECT, 32'h3);
    chk("spdOff", 32'h0, speedReached);
    wr(IDX_SPEED_TARGET, 32'h55);
    chk("spdReached", 32'h1, speedReached);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {resetn, odWrEn, odRdEn, overLimit, homeDone} = 5'h0;
    odIndex = 16'h0;
    odWrData = 32'h0;
    posDeviation = 32'sd0;
    speedIn = 32'sd0;
    miscompares = 0;
    checks_done = 0;
    step(3);
    resetn = 1'b1;
    regs_scn();
    handshake_scn();
    status_scn();
    follow_scn();
    end_of_test();
  end
endmodule // test_profile_motion_setpoint_unit
